// File: dv/arpss_midi_master.sv
// Behavioural MIDI master keyboard on the far side of the sequencer's MIDI ports
`timescale 1ns/1ps
module arpss_midi_master (
   input  wire logic                   i_clk_sys,
   input  wire logic                   i_rst_n,
   input  wire arpss_pkg::arpss_midi_t i_rx,
   output arpss_pkg::arpss_midi_t      o_tx,
   output logic                        o_sustain
);
   import arpss_pkg::*;
   int         cyc    = 0;
   int         rx_cnt = 0;
   int         cc_at;
   int         pc_at;
   logic [6:0] cc_bank;
   logic [6:0] pc_prog;
   logic [3:0] rx_chan;

   // Idle at time zero, pedal up
   initial begin
      o_tx = '0;
      o_sustain = 1'b0;
   end

   // Log what the device sends so the bench can compare bank, program and spacing
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (i_rx.valid === 1'b1) begin
         rx_cnt <= rx_cnt + 1;
         rx_chan <= i_rx.chan;
         if (i_rx.status == MIDI_CC) begin
            cc_bank <= i_rx.d2;
            cc_at <= cyc;
         end
         if (i_rx.status == MIDI_PC) begin
            pc_prog <= i_rx.d1;
            pc_at <= cyc;
         end
      end
   end

   // One-cycle message; idle fields carry the inverse so stale data never looks valid
   task automatic send(input logic [3:0] st, input logic [3:0] ch,
                       input logic [6:0] a, input logic [6:0] b);
      @(posedge i_clk_sys);
      o_tx <= '{1'b1, st, ch, a, b};
      @(posedge i_clk_sys);
      o_tx <= '{1'b0, ~st, ~ch, ~a, ~b};
   endtask : send

   // Pedal level sets the gate of entered steps
   task automatic pedal(input logic v);
      @(posedge i_clk_sys);
      o_sustain <= v;
   endtask : pedal
endmodule : arpss_midi_master

// File: dv/tb_top.sv
// Self-checking bench for the arpeggiator step sequencer
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
   import arpss_pkg::*;
   logic        i_clk_sys = 1'b0;
   logic        i_rst_n   = 1'b0;
   logic        psel      = 1'b0;
   logic        penable   = 1'b0;
   logic        pwrite    = 1'b0;
   logic [7:0]  paddr     = 8'h00;
   logic [31:0] pwdata    = 32'h0;
   logic        pready;
   logic        pslverr;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic        err;
   logic        sustain;
   arpss_midi_t m_tx;
   arpss_midi_t o_midi;
   arpss_note_t o_note;
   arpss_note_t trigs[$];
   logic [31:0] steps[5];
   int          bad_count = 0;
   int          compares  = 0;
   int          ties      = 0;
   int          n0;

   always #2.5 i_clk_sys = ~i_clk_sys;

   arpss_top #(.STEPS(64)) dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .i_midi(m_tx), .i_sustain(sustain),
      .o_midi(o_midi), .o_note(o_note));

   arpss_midi_master partner (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_rx(o_midi),
      .o_tx(m_tx), .o_sustain(sustain));

   // Collect new notes; tied steps are only counted since they carry no new note
   always @(posedge i_clk_sys) begin
      if (o_note.valid === 1'b1 && o_note.trig === 1'b1) trigs.push_back(o_note);
      else if (o_note.valid === 1'b1 && o_note.tie === 1'b1) ties++;
   end

   task automatic end_sim;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   // One APB transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge i_clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge i_clk_sys);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge i_clk_sys);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         bad_count++;
         end_sim();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wrd(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      apb(1'b0, a, 32'h0);
   endtask : wrd

   task automatic do_reset;
      i_rst_n <= 1'b0;
      repeat (16) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
   endtask : do_reset

   function automatic logic [31:0] sd(input arpss_gate_t g, input int v, input int n);
      return {19'h0, g, v[6:0], n[3:0]};
   endfunction : sd

   // Five-step pattern, two loops; exp_n holds the three expected notes, first in the low bits
   task automatic play(input logic [31:0] lo, input logic [31:0] hi, input logic [3:0] fl,
                       input logic [6:0] pat, input logic [20:0] exp_n, input int nh);
      int n;
      do_reset();
      for (n = 0; n < 5; n++) begin
         apb(1'b1, OFS_STEPSEL, n);
         apb(1'b1, OFS_STEPDAT, steps[n]);
      end
      apb(1'b1, OFS_KEYS_LO, lo);
      apb(1'b1, OFS_KEYS_HI, hi);
      apb(1'b1, OFS_RATE, 32'h7);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("held count", nh[6:0], rd[23:17]);
      trigs.delete();
      ties = 0;
      apb(1'b1, OFS_CTRL, {8'h40, 1'b0, 7'h05, 1'b0, pat, 4'h0, fl});
      for (n = 0; n < 400 && trigs.size() < 6; n++) @(posedge i_clk_sys);
      if (n == 400) begin
         bad_count++;
         end_sim();
      end
      // Stop after the second tie but just before the third loop starts
      repeat (18) @(posedge i_clk_sys);
      apb(1'b1, OFS_CTRL, 32'h0);
      `CHK("new notes", 6, trigs.size());
      `CHK("tied steps", 2, ties);
      for (n = 0; n < 6 && n < trigs.size(); n++) begin
         `CHK("note", exp_n[7*(n%3) +: 7], trigs[n].note);
         `CHK("velocity", 7'(10*(n%3+1)), trigs[n].vel);
         `CHK("gate length", 8'h40, trigs[n].gate_len);
         `CHK("glide", n%3 == 2 && fl[2], trigs[n].porta);
         `CHK("poly", pat >= PAT_POLY_FIRST, trigs[n].poly);
      end
      $display("test playback pattern %0d done", pat);
   endtask : play

   // Hang guard
   initial begin
      repeat (100000) @(posedge i_clk_sys);
      bad_count++;
      end_sim();
   end

   // Main sequence
   initial begin
      logic [2:0] cmd[6];
      logic [6:0] bnk[6];
      logic [6:0] prg[6];
      cmd = '{SEL_BANK_UP, SEL_PROG_UP, SEL_PROG_UP, SEL_BANK_DN, SEL_PROG_DN, SEL_MODE_PERF};
      bnk = '{BANK_B, BANK_B, BANK_B, BANK_A, BANK_A, BANK_PERF};
      prg = '{7'h00, 7'h01, 7'h02, 7'h02, 7'h01, 7'h00};
      steps = '{sd(ARPSS_GATE_NORM, 10, 3), sd(ARPSS_GATE_GLIDE, 20, 1),
                sd(ARPSS_GATE_NORM, 30, 2), sd(ARPSS_GATE_REST, 0, 1), sd(ARPSS_GATE_TIE, 0, 1)};
      do_reset();
      apb(1'b0, OFS_RATE, 32'h0);
      `CHK("rate reset", {16'h0, RATE_RST}, rd);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("status reset", 32'h0, rd);
      apb(1'b0, 8'h24, 32'h0);
      `CHK("unmapped", 33'h1_0000_0000, {err, rd});
      $display("test reset done");
      // Local selection changes, each answered by bank select then program change
      apb(1'b1, OFS_CTRL, 32'h50);
      for (int i = 0; i < 6; i++) begin
         n0 = partner.rx_cnt;
         apb(1'b1, OFS_SEL, {29'h0, cmd[i]});
         repeat (8) @(posedge i_clk_sys);
         `CHK("tx count", 2, partner.rx_cnt - n0);
         `CHK("tx chan", 4'h5, partner.rx_chan);
         `CHK("tx bank", bnk[i], partner.cc_bank);
         `CHK("tx spacing", 1, partner.pc_at - partner.cc_at);
         apb(1'b0, OFS_STATUS, 32'h0);
         if (i < 5) begin
            `CHK("tx prog", prg[i], partner.pc_prog);
            `CHK("selection", {1'b0, bnk[i] == BANK_B, prg[i]}, rd[16:8]);
         end else `CHK("perf mode", 1'b1, rd[16]);
      end
      $display("test selection done");
      // Remote selection on the global channel, then a part channel in performance
      apb(1'b1, OFS_SEL, {29'h0, SEL_MODE_PROG});
      repeat (8) @(posedge i_clk_sys);
      partner.send(MIDI_CC, 4'h5, CC_BANK, BANK_B);
      partner.send(MIDI_PC, 4'h5, 7'h07, 7'h00);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("rx program", 9'h087, rd[16:8]);
      partner.send(MIDI_CC, 4'h5, CC_BANK, BANK_PERF);
      partner.send(MIDI_PC, 4'h5, 7'h03, 7'h00);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("rx perf", 8'h83, {rd[16], rd[14:8]});
      partner.send(MIDI_PC, 4'h2, 7'h09, 7'h00);
      apb(1'b0, OFS_STATUS, 32'h0);
      `CHK("part only", 8'h83, {rd[16], rd[14:8]});
      $display("test midi receive done");
      // Step entry from the keyboard, then note edits that must be kept or clamped
      do_reset();
      apb(1'b1, OFS_STEPSEL, 32'h0);
      partner.send(4'h9, 4'h0, 7'd14, 7'd100);
      partner.pedal(1'b1);
      partner.send(4'h9, 4'h0, 7'd3, 7'd50);
      partner.pedal(1'b0);
      apb(1'b1, OFS_STEPSEL, 32'h0);
      apb(1'b0, OFS_STEPDAT, 32'h0);
      `CHK("entry 0", sd(ARPSS_GATE_NORM, 100, 3), rd);
      apb(1'b1, OFS_STEPSEL, 32'h1);
      apb(1'b0, OFS_STEPDAT, 32'h0);
      `CHK("entry 1", sd(ARPSS_GATE_TIE, 50, 4), rd);
      wrd(OFS_STEPDAT, sd(ARPSS_GATE_TIE, 50, 9));
      `CHK("tie keeps note", 4'h4, rd[3:0]);
      wrd(OFS_STEPDAT, sd(ARPSS_GATE_GLIDE, 1, 15));
      `CHK("note clamp high", 4'hC, rd[3:0]);
      wrd(OFS_STEPDAT, sd(ARPSS_GATE_NORM, 1, 0));
      `CHK("note clamp low", 4'h1, rd[3:0]);
      $display("test step entry done");
      play(32'h0010_0220, 32'h2, 4'b0101, 7'd5, {7'd9, 7'd5, 7'd20}, 4);
      play(32'h220, 32'h0, 4'b1101, 7'd63, {7'd9, 7'd5, 7'd9}, 2);
      play(32'h220, 32'h0, 4'b0011, 7'd0, {7'd5, 7'd9, 7'd5}, 2);
      play(32'h220, 32'h0, 4'b0101, 7'd64, {7'd7, 7'd6, 7'd8}, 2);
      end_sim();
   end
endmodule : tb_top

// File: rtl/arpss_pkg.sv
// Package for the arpeggiator step sequencer: register map, fields, types
package arpss_pkg;
   // Register byte offsets (APB, 32-bit words)
   localparam logic [7:0] OFS_CTRL    = 8'h00;
   localparam logic [7:0] OFS_SEL     = 8'h04;
   localparam logic [7:0] OFS_RATE    = 8'h08;
   localparam logic [7:0] OFS_STEPSEL = 8'h0C;
   localparam logic [7:0] OFS_STEPDAT = 8'h10;
   localparam logic [7:0] OFS_KEYS_LO = 8'h14;
   localparam logic [7:0] OFS_KEYS_HI = 8'h18;
   localparam logic [7:0] OFS_STATUS  = 8'h1C;
   localparam logic [7:0] OFS_PARTCH  = 8'h20;
   // Control field positions
   localparam int CTRL_RUN_BIT   = 0;
   localparam int CTRL_GAP_BIT   = 1;
   localparam int CTRL_MONO_BIT  = 2;
   localparam int CTRL_FIXP_BIT  = 3;
   localparam int CTRL_GLOBAL_LO = 4;
   localparam int CTRL_PAT_LO    = 8;
   localparam int CTRL_LEN_LO    = 16;
   localparam int CTRL_GATE_LO   = 24;
   // Selection command codes written to OFS_SEL bits [2:0]
   localparam logic [2:0] SEL_BANK_UP   = 3'h1;
   localparam logic [2:0] SEL_BANK_DN   = 3'h2;
   localparam logic [2:0] SEL_PROG_UP   = 3'h3;
   localparam logic [2:0] SEL_PROG_DN   = 3'h4;
   localparam logic [2:0] SEL_MODE_PERF = 3'h5;
   localparam logic [2:0] SEL_MODE_PROG = 3'h6;
   // Sizes and limits
   localparam int BANK_SIZE      = 128;
   localparam int MAX_STEPS      = 64;
   localparam int NOTE_VALUES    = 12;
   localparam int NUM_PARTS      = 6;
   localparam logic [6:0] PAT_POLY_FIRST = 7'h40;
   // Reset values
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [15:0] RATE_RST     = 16'h00FF;
   localparam logic [6:0]  STEPCNT_RST  = 7'h08;
   // MIDI message status nibbles and the bank select controller number
   localparam logic [3:0] MIDI_CC = 4'hB;
   localparam logic [3:0] MIDI_PC = 4'hC;
   localparam logic [6:0] CC_BANK = 7'h00;
   // Bank numbers sent with bank select
   localparam logic [6:0] BANK_PERF = 7'h00;
   localparam logic [6:0] BANK_A    = 7'h01;
   localparam logic [6:0] BANK_B    = 7'h02;

   typedef enum logic [1:0] {
      ARPSS_GATE_NORM  = 2'b00,
      ARPSS_GATE_TIE   = 2'b01,
      ARPSS_GATE_REST  = 2'b11,
      ARPSS_GATE_GLIDE = 2'b10
   } arpss_gate_t;

   typedef struct packed {
      arpss_gate_t gate;
      logic [6:0]  vel;
      logic [3:0]  note;  // 1..12, 0 unused
   } arpss_step_t;

   typedef struct packed {
      logic       valid;
      logic [3:0] status;
      logic [3:0] chan;
      logic [6:0] d1;
      logic [6:0] d2;
   } arpss_midi_t;

   typedef struct packed {
      logic       valid;
      logic       trig;     // new note on
      logic       tie;
      logic       porta;
      logic       poly;
      logic [6:0] note;
      logic [6:0] vel;
      logic [7:0] gate_len;
   } arpss_note_t;
endpackage : arpss_pkg

// File: rtl/arpss_top.sv
// Arpeggiator step sequencer with sound selection and MIDI bank/program exchange
// Summary of operation
// - Sounds sit in banks of 128: one performance bank, program banks A and B.
// - Bank up selects B, bank down selects A; program up adds one.
// - Every local selection change made while the transmitter is idle sends MIDI bank select and program change.
// - Bank select and program change on the global channel change current sound.
// - In performance, messages on a part channel change only that part.
// - Mono patterns play held notes in order; poly patterns sound all, transposed.
// - User patterns 000 to 063 are monophonic.
// - Pattern length is one to 64 steps, set by step count.
// - Held keys are labelled from 1 upward starting at the lowest.
// - Each step stores a note index, editable over APB only for normal or glide gates.
// - Gap fill off: held notes no step names stay silent.
// - Gap fill off: a missing index plays the highest held index instead.
// - Gap fill on: missing notes are inserted so all held notes are used.
// - Mono note index values are limited to twelve values.
// - Each step carries its own velocity, used for that step's note.
// - Normal gate uses the global gate length.
// - Tie gate extends the previous note without retriggering.
// - Rest gate plays no note.
// - Glide gate engages portamento into the next step, then releases it.
// - Glide only acts when the voice allocation is mono.
// - External keyboard enters note and velocity per step; sustain sets gate.
// - Fixed pitch option has no effect on monophonic patterns.
// - User patterns 064 to 127 are polyphonic, transposing.
`timescale 1ns/1ps
module arpss_top #(
   parameter int STEPS = 64
) (
   input  wire logic               i_clk_sys,
   input  wire logic               i_rst_n,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic                    pready,
   output logic                    pslverr,
   output logic [31:0]             prdata,
   // MIDI message in and out
   input  wire arpss_pkg::arpss_midi_t i_midi,
   input  wire logic               i_sustain,
   output arpss_pkg::arpss_midi_t  o_midi,
   // Note event stream towards the voices
   output arpss_pkg::arpss_note_t  o_note
);
   import arpss_pkg::*;

   // Transmit sequencer: IDLE to BANK and BANK to PROG flip one bit, PROG back to IDLE flips both
   typedef enum logic [1:0] {
      ARPSS_TX_IDLE = 2'b00,
      ARPSS_TX_BANK = 2'b01,
      ARPSS_TX_PROG = 2'b11
   } arpss_tx_t;

   // Registers
   logic [31:0]     ctrl_q;
   logic [15:0]     rate_q;
   logic [5:0]      edit_q;
   logic [63:0]     keys_q;
   logic            perf_q;
   logic            bank_b_q;
   logic [6:0]      prog_q;
   logic [6:0]      pend_bank_q;
   logic [6:0]      part_prog_q [NUM_PARTS];
   logic [3:0]      part_ch_q [NUM_PARTS];
   logic [6:0]      rx_bank_q;
   arpss_step_t     pat_q [STEPS];
   logic [5:0]      step_q;
   logic [15:0]     tick_q;
   logic [6:0]      last_note_q;
   logic            porta_q;
   arpss_tx_t       tx_ph_q;
   arpss_midi_t     midi_q;
   arpss_note_t     note_q;
   logic [31:0]     prdata_q;
   logic            rec_sus_q;

   // Control fields
   wire        run     = ctrl_q[CTRL_RUN_BIT];
   wire        gapfill = ctrl_q[CTRL_GAP_BIT];
   wire        monov   = ctrl_q[CTRL_MONO_BIT];
   wire [3:0]  gch     = ctrl_q[CTRL_GLOBAL_LO +: 4];
   wire [6:0]  pat_no  = ctrl_q[CTRL_PAT_LO +: 7];
   wire [6:0]  len_raw = ctrl_q[CTRL_LEN_LO +: 7];
   wire [7:0]  gatelen = ctrl_q[CTRL_GATE_LO +: 8];
   // Length clamped to 1..64; fixed pitch bit is stored but never read
   wire [6:0]  len     = (len_raw == 7'h00) ? 7'h01 :
                         (len_raw > 7'(MAX_STEPS)) ? 7'(MAX_STEPS) : len_raw;
   wire        is_poly = (pat_no >= PAT_POLY_FIRST);

   // APB decode
   wire acc  = psel & penable;
   wire wr   = acc & pwrite;
   wire rd   = acc & ~pwrite;
   wire hit  = (paddr <= OFS_PARTCH) && (paddr[1:0] == 2'b00);
   wire sel_wr = wr && paddr == OFS_SEL;
   wire [2:0] sel_cmd = pwdata[2:0];

   // Held key count and rank lookup
   function automatic logic [6:0] popcnt(input logic [63:0] v);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 0; i < 64; i++) c = c + 7'(v[i]);
      return c;
   endfunction : popcnt

   // Returns key number of the k-th held key counted from the lowest (k from 1)
   function automatic logic [6:0] nth_key(input logic [63:0] v, input logic [6:0] k);
      logic [6:0] c;
      logic [6:0] r;
      c = 7'h00;
      r = 7'h00;
      for (int i = 0; i < 64; i++) begin
         if (v[i]) begin
            c = c + 7'h01;
            if (c == k) r = 7'(i);
         end
      end
      return r;
   endfunction : nth_key

   wire [6:0]   nheld   = popcnt(keys_q);
   arpss_step_t cur;
   assign cur = pat_q[step_q];
   wire [6:0]   cur_idx = {3'b000, cur.note};
   // Gap fill on cycles through all held notes by step position; off uses stored index
   wire [6:0]   fill_idx = (nheld == 7'h00) ? 7'h00 : 7'(({1'b0, step_q} % nheld) + 7'h01);
   wire [6:0]   use_idx  = gapfill ? fill_idx
                         : (cur_idx > nheld) ? nheld : cur_idx;
   wire [6:0]   mono_key = nth_key(keys_q, use_idx);
   wire [6:0]   low_key  = nth_key(keys_q, 7'h01);
   wire         step_end = (tick_q == 16'h0000);
   wire [6:0]   next_step = (7'({1'b0, step_q}) + 7'h01 >= len) ? 7'h00
                          : 7'({1'b0, step_q}) + 7'h01;

   // Incoming MIDI classification
   wire rx_global = i_midi.valid && i_midi.chan == gch;
   wire rx_cc     = i_midi.valid && i_midi.status == MIDI_CC && i_midi.d1 == CC_BANK;
   wire rx_pc     = i_midi.valid && i_midi.status == MIDI_PC;
   wire rx_note   = i_midi.valid && i_midi.status == 4'h9 && i_midi.d2 != 7'h00;

   // APB register writes and edit port
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         ctrl_q <= CTRL_RST | (32'(STEPCNT_RST) << CTRL_LEN_LO);
         rate_q <= RATE_RST;
         edit_q <= 6'h00;
         keys_q <= 64'h0;
      end else if (wr) begin
         unique case (paddr)
            OFS_CTRL:    ctrl_q <= pwdata;
            OFS_RATE:    rate_q <= pwdata[15:0];
            OFS_STEPSEL: edit_q <= pwdata[5:0];
            OFS_KEYS_LO: keys_q[31:0] <= pwdata;
            OFS_KEYS_HI: keys_q[63:32] <= pwdata;
            default: ;
         endcase
      end else if (rx_note && !run) begin
         // Keyboard entry moves to the next step after each note
         edit_q <= (7'({1'b0, edit_q}) + 7'h01 >= len) ? 6'h00 : edit_q + 6'h01;
      end
   end

   // Pattern memory: APB edits and keyboard step entry
   always_ff @(posedge i_clk_sys) begin
      rec_sus_q <= i_sustain;
      if (wr && paddr == OFS_STEPDAT) begin
         pat_q[edit_q].gate <= arpss_gate_t'(pwdata[12:11]);
         pat_q[edit_q].vel  <= pwdata[10:4];
         // Index only changes for normal or glide gates, and stays within 1..12
         if (pwdata[12:11] == ARPSS_GATE_NORM || pwdata[12:11] == ARPSS_GATE_GLIDE) begin
            pat_q[edit_q].note <= (pwdata[3:0] == 4'h0) ? 4'h1 :
                                  (pwdata[3:0] > 4'(NOTE_VALUES)) ? 4'(NOTE_VALUES)
                                  : pwdata[3:0];
         end
      end else if (rx_note && !run) begin
         // Note index is key number modulo 12 plus one, velocity as played, sustain gives tie
         pat_q[edit_q].vel  <= i_midi.d2;
         pat_q[edit_q].gate <= rec_sus_q ? ARPSS_GATE_TIE : ARPSS_GATE_NORM;
         pat_q[edit_q].note <= 4'((i_midi.d1 % 7'(NOTE_VALUES)) + 7'h01);
      end
   end

   // Sound selection: local buttons and MIDI reception
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         perf_q      <= 1'b0;
         bank_b_q    <= 1'b0;
         prog_q      <= 7'h00;
         rx_bank_q   <= BANK_A;
         for (int p = 0; p < NUM_PARTS; p++) begin
            part_prog_q[p] <= 7'h00;
            part_ch_q[p]   <= 4'(p);
         end
      end else begin
         if (sel_wr) begin
            unique case (sel_cmd)
               SEL_BANK_UP:   bank_b_q <= 1'b1;
               SEL_BANK_DN:   bank_b_q <= 1'b0;
               SEL_PROG_UP:   prog_q   <= prog_q + 7'h01;
               SEL_PROG_DN:   prog_q   <= prog_q - 7'h01;
               SEL_MODE_PERF: perf_q   <= 1'b1;
               SEL_MODE_PROG: perf_q   <= 1'b0;
               default: ;
            endcase
         end
         if (wr && paddr == OFS_PARTCH && pwdata[6:4] < 3'(NUM_PARTS))
            part_ch_q[pwdata[6:4]] <= pwdata[3:0];
         // Part-channel bank selects must not disturb the bank of the global sound
         if (rx_cc && rx_global) rx_bank_q <= i_midi.d2;
         // Global channel switches the current sound
         if (rx_pc && rx_global) begin
            perf_q   <= (rx_bank_q == BANK_PERF);
            bank_b_q <= (rx_bank_q == BANK_B);
            prog_q   <= i_midi.d1;
         end
         // Part channels act on their part only in performance mode
         for (int p = 0; p < NUM_PARTS; p++) begin
            if (rx_pc && !rx_global && perf_q && part_ch_q[p] == i_midi.chan)
               part_prog_q[p] <= i_midi.d1;
         end
      end
   end

   // MIDI transmit: bank select then program change after a local change
   wire local_chg = sel_wr && sel_cmd != 3'h0 && sel_cmd != 3'h7;
   wire [6:0] cur_bank = perf_q ? BANK_PERF : (bank_b_q ? BANK_B : BANK_A);
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         tx_ph_q <= ARPSS_TX_IDLE;
         midi_q  <= '0;
      end else begin
         midi_q.valid <= 1'b0;
         unique case (tx_ph_q)
            ARPSS_TX_IDLE: if (local_chg) tx_ph_q <= ARPSS_TX_BANK;
            ARPSS_TX_BANK: begin
               midi_q  <= '{1'b1, MIDI_CC, gch, CC_BANK, cur_bank};
               tx_ph_q <= ARPSS_TX_PROG;
            end
            ARPSS_TX_PROG: begin
               midi_q  <= '{1'b1, MIDI_PC, gch, prog_q, 7'h00};
               tx_ph_q <= ARPSS_TX_IDLE;
            end
            default: tx_ph_q <= ARPSS_TX_IDLE;
         endcase
      end
   end
   assign o_midi = midi_q;

   // Step timing and note generation
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
         step_q      <= 6'h00;
         tick_q      <= RATE_RST;
         last_note_q <= 7'h00;
         porta_q     <= 1'b0;
         note_q      <= '0;
      end else if (!run) begin
         step_q <= 6'h00;
         tick_q <= rate_q;
         note_q <= '0;
         porta_q <= 1'b0;  // A stale glide must not slide into the next run
      end else begin
         note_q.valid <= 1'b0;
         note_q.trig  <= 1'b0;
         tick_q <= step_end ? rate_q : tick_q - 16'h0001;
         if (step_end) begin
            step_q <= next_step[5:0];
            note_q.valid    <= (nheld != 7'h00) && cur.gate != ARPSS_GATE_REST;
            note_q.trig     <= cur.gate != ARPSS_GATE_TIE;
            note_q.tie      <= cur.gate == ARPSS_GATE_TIE;
            note_q.vel      <= cur.vel;
            note_q.gate_len <= gatelen;
            note_q.poly     <= is_poly;
            // Poly pattern transposes the held chord from its lowest note
            note_q.note     <= is_poly ? 7'(low_key + cur_idx)
                              : (cur.gate == ARPSS_GATE_TIE ? last_note_q : mono_key);
            if (!is_poly && cur.gate != ARPSS_GATE_TIE) last_note_q <= mono_key;
            // Portamento lives for the transition out of a glide step
            porta_q       <= cur.gate == ARPSS_GATE_GLIDE && monov;
            note_q.porta  <= porta_q && monov;
         end
      end
   end
   assign o_note = note_q;

   // APB read mux
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) prdata_q <= 32'h0;
      else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFS_CTRL:    prdata_q <= ctrl_q;
            OFS_RATE:    prdata_q <= {16'h0000, rate_q};
            OFS_STEPSEL: prdata_q <= {26'h0, edit_q};
            OFS_STEPDAT: prdata_q <= {19'h0, pat_q[edit_q]};
            OFS_KEYS_LO: prdata_q <= keys_q[31:0];
            OFS_KEYS_HI: prdata_q <= keys_q[63:32];
            OFS_STATUS:  prdata_q <= {8'h00, nheld, perf_q, bank_b_q, prog_q, 2'b00, step_q};
            default:     prdata_q <= 32'h0;
         endcase
      end
   end
   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = acc & ~hit;
   wire unused = rd;

   // Checks
   AST_WRAP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      run && step_end && 7'({1'b0, step_q}) + 7'h01 >= len |=> step_q == 6'h00)
      else $error("step counter did not wrap");
   AST_REST: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      run && step_end && cur.gate == ARPSS_GATE_REST |=> !o_note.valid)
      else $error("rest step sounded");
   AST_TIE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      run && step_end && cur.gate == ARPSS_GATE_TIE |=> !o_note.trig)
      else $error("tie step retriggered");
   AST_VEL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      run && step_end |=> o_note.vel == $past(cur.vel))
      else $error("step velocity not applied");
   AST_TX: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      tx_ph_q == ARPSS_TX_IDLE && local_chg |=> ##1 o_midi.valid && o_midi.status == MIDI_CC
      ##1 o_midi.valid && o_midi.status == MIDI_PC)
      else $error("selection change not transmitted");
   AST_BANKUP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      sel_wr && sel_cmd == SEL_BANK_UP && !(rx_pc && rx_global) |=> bank_b_q)
      else $error("bank up failed");
   AST_GLOBAL: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      rx_pc && rx_global |=> prog_q == $past(i_midi.d1))
      else $error("global program change ignored");
   // A part-channel program change must leave the current sound alone
   AST_PART: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      rx_pc && !rx_global && !sel_wr |=>
      {perf_q, bank_b_q, prog_q} == $past({perf_q, bank_b_q, prog_q}))
      else $error("part program change moved the current sound");
   AST_GLIDE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      run && step_end && !monov |=> !o_note.porta)
      else $error("glide active in poly voice mode");
   // Pattern class follows the top bit of the pattern number
   AST_POLY: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      run && step_end |=> o_note.poly == $past(pat_no[6]))
      else $error("pattern class wrong on step output");
   COV_TIE:   cover property (@(posedge i_clk_sys) run && step_end && cur.gate == ARPSS_GATE_TIE);
   COV_GLIDE: cover property (@(posedge i_clk_sys) porta_q && o_note.valid);
   COV_TX:    cover property (@(posedge i_clk_sys) o_midi.valid);
   COV_FILL:  cover property (@(posedge i_clk_sys) run && step_end && gapfill && nheld > 7'h04);
endmodule : arpss_top
